//--- core/eac_top.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "eac_regs.svh"

// Overview of operation
// - Write-start set by software, cleared on completion
// - Read-start self-clears; software cannot clear it
// - Read byte lands in data register next cycle when data memory selected
// - Data register holds until read or write
// - Write needs 55h, AAh, then write-start
// - Write-start ignored while write-enable clear
// - Write-enable changes only by software
// - Clearing write-enable never aborts a write
// - Completion clears write-start and sets done flag
// - Done flag set by hardware, cleared by software
// - Each write programs one whole data byte
// - Unlock register reads as zero
// - Aborted write sets error; normal completion clears
// - Memory select resets zero, frozen while busy
module eac_top
#(
  parameter int unsigned WRITE_CYCLES = `EAC_WRITE_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_reset_req,
  output logic             write_busy,
  output logic             write_done_flag
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `EAC_OFS_CTRL) || (a == `EAC_OFS_UNLOCK) ||
                (a == `EAC_OFS_ADDR) || (a == `EAC_OFS_DATA) ||
                (a == `EAC_OFS_FLAG);
  endfunction

  logic setup_ph;
  logic acc_wr;
  logic wr_ctrl;
  logic wr_unlock;
  logic wr_addr;
  logic wr_data;
  logic wr_flag;

  // Writes land at the access edge; no wait states
  assign setup_ph  = psel & ~penable;
  assign acc_wr    = psel & penable & pwrite;
  assign wr_ctrl   = acc_wr & (paddr == `EAC_OFS_CTRL);
  assign wr_unlock = acc_wr & (paddr == `EAC_OFS_UNLOCK);
  assign wr_addr   = acc_wr & (paddr == `EAC_OFS_ADDR);
  assign wr_data   = acc_wr & (paddr == `EAC_OFS_DATA);
  assign wr_flag   = acc_wr & (paddr == `EAC_OFS_FLAG);
  assign pready    = 1'b1;

  // ----------------------------------------
  // External reset request synchroniser
  // ----------------------------------------
  logic abort_meta;
  logic abort_req;

  // Pin is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      abort_meta <= 1'b0;
      abort_req  <= 1'b0;
    end
    else
    begin
      abort_meta <= ext_reset_req;
      abort_req  <= abort_meta;
    end
  end

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic                   msel;
  logic                   werr;
  logic                   wen;
  logic                   wr;
  logic                   rd;
  logic                   done;
  eac_pkg::eac_byte_t     addr;
  eac_pkg::eac_byte_t     data;
  eac_pkg::eac_byte_t     lat_addr;
  eac_pkg::eac_byte_t     lat_data;
  logic [`EAC_CNT_W-1:0]  cnt;
  logic                   next_msel;
  logic                   next_werr;
  logic                   next_wen;
  logic                   next_wr;
  logic                   next_rd;
  logic                   next_done;
  eac_pkg::eac_byte_t     next_addr;
  eac_pkg::eac_byte_t     next_data;
  eac_pkg::eac_byte_t     next_lat_addr;
  eac_pkg::eac_byte_t     next_lat_data;
  logic [`EAC_CNT_W-1:0]  next_cnt;
  logic                   armed;
  logic                   start;
  logic                   finish;
  logic                   abort;
  eac_pkg::eac_byte_t     rd_byte;

  // Start only when unlocked, enabled, idle and data memory selected
  assign start  = wr_ctrl & pwdata[`EAC_BIT_WR] & wen & armed
                & ~msel & ~wr;
  assign abort  = wr & abort_req;
  assign finish = wr & ~abort_req & (cnt == `EAC_CNT_W'(1));

  eac_unlock u_unlock
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (wr_unlock),
    .key_data (pwdata[7:0]),
    .other_wr (acc_wr & ~wr_unlock & ~wr_ctrl),
    .consume  (wr_ctrl),
    .armed    (armed)
  );

  // Array writes from latched copies so later bus writes cannot disturb
  eac_nv_array u_array
  (
    .pclk  (pclk),
    .we    (finish),
    .waddr (lat_addr),
    .wdata (lat_data),
    .raddr (addr),
    .rdata (rd_byte)
  );

  // Next values for all control fields
  always_comb
  begin
    next_msel     = msel;
    next_werr     = werr;
    next_wen      = wen;
    next_wr       = wr;
    next_rd       = 1'b0;
    next_done     = done;
    next_addr     = addr;
    next_data     = data;
    next_lat_addr = lat_addr;
    next_lat_data = lat_data;
    next_cnt      = cnt;
    if (wr_ctrl)
    begin
      if (!wr)
        next_msel = pwdata[`EAC_BIT_MSEL];
      next_werr = pwdata[`EAC_BIT_WERR];
      next_wen  = pwdata[`EAC_BIT_WEN];
      if (pwdata[`EAC_BIT_RD])
      begin
        next_rd = 1'b1;
        if (!msel)
          next_data = rd_byte;
      end
    end
    if (wr_addr)
      next_addr = pwdata[7:0];
    if (wr_data)
      next_data = pwdata[7:0];
    // Busy tracking ignores the enable bit once started
    if (start)
    begin
      next_wr       = 1'b1;
      next_cnt      = `EAC_CNT_W'(WRITE_CYCLES);
      next_lat_addr = addr;
      next_lat_data = data;
    end
    else if (abort)
    begin
      next_wr   = 1'b0;
      next_werr = 1'b1;
    end
    else if (finish)
    begin
      next_wr   = 1'b0;
      next_werr = 1'b0;
    end
    else if (wr)
    begin
      next_cnt = cnt - `EAC_CNT_W'(1);
    end
    // Set wins over a clear in the same cycle
    if (wr_flag && pwdata[`EAC_BIT_DONE])
      next_done = 1'b0;
    if (finish)
      next_done = 1'b1;
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msel     <= 1'b0;
      werr     <= 1'b0;
      wen      <= 1'b0;
      wr       <= 1'b0;
      rd       <= 1'b0;
      done     <= 1'b0;
      addr     <= `EAC_BYTE_RST;
      data     <= `EAC_BYTE_RST;
      lat_addr <= `EAC_BYTE_RST;
      lat_data <= `EAC_BYTE_RST;
      cnt      <= '0;
    end
    else
    begin
      msel     <= next_msel;
      werr     <= next_werr;
      wen      <= next_wen;
      wr       <= next_wr;
      rd       <= next_rd;
      done     <= next_done;
      addr     <= next_addr;
      data     <= next_data;
      lat_addr <= next_lat_addr;
      lat_data <= next_lat_data;
      cnt      <= next_cnt;
    end
  end

  assign write_busy      = wr;
  assign write_done_flag = done;

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  logic [31:0] next_prdata;
  logic        next_slverr;

  // Captured in setup so data is a flop by the access phase
  always_comb
  begin
    next_prdata = prdata;
    next_slverr = pslverr;
    if (setup_ph)
    begin
      next_slverr = ~is_mapped(paddr);
      next_prdata = 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          `EAC_OFS_CTRL:
            next_prdata[7:0] = {msel, 3'b000, werr, wen, wr, rd};
          `EAC_OFS_ADDR:
            next_prdata[7:0] = addr;
          `EAC_OFS_DATA:
            next_prdata[7:0] = data;
          `EAC_OFS_FLAG:
            next_prdata[`EAC_BIT_DONE] = done;
          default:
            next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pslverr <= next_slverr;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [`EAC_CNT_W-1:0] busy_len;

  // Length of the current busy period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_len <= '0;
    else if (wr)
      busy_len <= busy_len + `EAC_CNT_W'(1);
    else
      busy_len <= '0;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_unlocked_start;
    armed && wen && !msel && !wr && wr_ctrl && pwdata[`EAC_BIT_WR];
  endsequence

  sequence s_normal_end;
    wr && !abort_req && (cnt == `EAC_CNT_W'(1));
  endsequence

  a_wr_set_only: assert property (
    wr && wr_ctrl && !pwdata[`EAC_BIT_WR] && !abort_req && cnt > 1 |=> wr)
    else $error("busy bit cleared by software write");

  a_rd_self_clear: assert property (rd |=> !rd)
    else $error("read-start bit did not clear");

  a_read_next: assert property (
    wr_ctrl && pwdata[`EAC_BIT_RD] && !msel |=> data == $past(rd_byte))
    else $error("read byte missing from data register");

  a_data_hold: assert property (
    !(wr_ctrl && pwdata[`EAC_BIT_RD]) && !wr_data |=> $stable(data))
    else $error("data register changed without cause");

  a_unlock_gate: assert property ($rose(wr) |-> $past(armed))
    else $error("write began without unlock sequence");

  a_wen_gate: assert property ($rose(wr) |-> $past(wen))
    else $error("write began with write-enable clear");

  a_wen_sw_only: assert property ($changed(wen) |-> $past(wr_ctrl))
    else $error("write-enable changed by hardware");

  // An external abort may end the cycle one clock after it begins
  a_start_seq: assert property (
    s_unlocked_start |=> wr ##1 (wr || $past(abort_req)))
    else $error("unlocked start did not begin write");

  a_cycle_kept: assert property (
    wr && !abort_req && cnt > 1 |=> wr)
    else $error("write cycle cut short");

  a_done_pair: assert property (
    s_normal_end |=> !wr && done && !werr)
    else $error("completion did not clear busy and set flag");

  a_done_sticky: assert property (
    done && !(wr_flag && pwdata[`EAC_BIT_DONE]) |=> done)
    else $error("done flag lost without software clear");

  a_unlock_zero: assert property (
    setup_ph && !pwrite && paddr == `EAC_OFS_UNLOCK |=> prdata == 32'h0)
    else $error("unlock register read nonzero");

  a_abort_err: assert property (
    wr && abort_req |=> werr && !wr && !$rose(done))
    else $error("aborted write not flagged");

  a_msel_frozen: assert property (wr |=> msel == $past(msel))
    else $error("memory select changed while busy");

  a_busy_len: assert property (
    s_normal_end |-> busy_len == `EAC_CNT_W'(WRITE_CYCLES - 1))
    else $error("busy period length wrong");

endmodule

//--- core/eac_regs.svh
`ifndef EAC_REGS_SVH
`define EAC_REGS_SVH

// ----------------------------------------
// Register byte offsets on the APB
// ----------------------------------------
`define EAC_OFS_CTRL   8'h00
`define EAC_OFS_UNLOCK 8'h04
`define EAC_OFS_ADDR   8'h08
`define EAC_OFS_DATA   8'h0C
`define EAC_OFS_FLAG   8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EAC_BIT_MSEL 7
`define EAC_BIT_WERR 3
`define EAC_BIT_WEN  2
`define EAC_BIT_WR   1
`define EAC_BIT_RD   0
`define EAC_BIT_DONE 0

// ----------------------------------------
// Reset values and unlock keys
// ----------------------------------------
`define EAC_BYTE_RST 8'h00
`define EAC_KEY_FIRST  8'h55
`define EAC_KEY_SECOND 8'hAA

// ----------------------------------------
// Timing
// ----------------------------------------
`define EAC_CLK_PERIOD_NS 4
`define EAC_WRITE_TIME_NS 4000
`define EAC_WRITE_CYCLES \
  ((`EAC_WRITE_TIME_NS + `EAC_CLK_PERIOD_NS - 1) / `EAC_CLK_PERIOD_NS)
`define EAC_CNT_W 16

`endif

//--- core/eac_pkg.sv
package eac_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [7:0] eac_byte_t;

  // Unlock sequence progress, one-hot
  typedef enum logic [2:0]
  {
    ul_idle  = 3'b001,
    ul_key1  = 3'b010,
    ul_armed = 3'b100
  } eac_unlock_e;

endpackage

//--- core/eac_nv_array.sv
`timescale 1ns/100ps

module eac_nv_array
(
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire eac_pkg::eac_byte_t waddr,
  input  wire eac_pkg::eac_byte_t wdata,
  input  wire eac_pkg::eac_byte_t raddr,
  output eac_pkg::eac_byte_t      rdata
);

  // ----------------------------------------
  // Byte storage
  // ----------------------------------------
  // No reset: contents model nonvolatile cells
  eac_pkg::eac_byte_t mem [0:255];

  // Whole byte programmed at once
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Combinational read port
  assign rdata = mem[raddr];

endmodule

//--- core/eac_unlock.sv
`timescale 1ns/100ps
`include "eac_regs.svh"

module eac_unlock
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               key_wr,
  input  wire eac_pkg::eac_byte_t key_data,
  input  wire logic               other_wr,
  input  wire logic               consume,
  output logic                    armed
);

  // ----------------------------------------
  // Sequence tracker
  // ----------------------------------------
  eac_pkg::eac_unlock_e state;
  eac_pkg::eac_unlock_e next_state;

  // Any off-pattern write drops back to idle; a 55h key write always moves to the first-key state
  always_comb
  begin
    next_state = state;
    if (consume)
    begin
      next_state = eac_pkg::ul_idle;
    end
    else if (key_wr)
    begin
      case (state)
        eac_pkg::ul_key1:
          if (key_data == `EAC_KEY_SECOND)
            next_state = eac_pkg::ul_armed;
          else if (key_data == `EAC_KEY_FIRST)
            next_state = eac_pkg::ul_key1;
          else
            next_state = eac_pkg::ul_idle;
        default:
          if (key_data == `EAC_KEY_FIRST)
            next_state = eac_pkg::ul_key1;
          else
            next_state = eac_pkg::ul_idle;
      endcase
    end
    else if (other_wr)
    begin
      next_state = eac_pkg::ul_idle;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= eac_pkg::ul_idle;
    else
      state <= next_state;
  end

  assign armed = (state == eac_pkg::ul_armed);

endmodule

//--- sim/tb_data_eeprom_access_control.sv
`timescale 1ns/100ps
`include "eac_regs.svh"

module tb_data_eeprom_access_control;
  // Short write time keeps the run brief; every busy figure except the aborted write's zero derives from it
  localparam int unsigned WC = 40;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_reset_req;
  logic        write_busy;
  logic        write_done_flag;
  logic [32:0] exp_q[$];
  int          n_mismatch;
  int          n_compared;
  int          c;
  logic [7:0]  a0;
  logic [7:0]  d0;
  logic [7:0]  d2;
  logic [7:0]  seq_a[4][3];
  logic [7:0]  seq_d[4][3];

  eac_top #(.WRITE_CYCLES(WC)) dut_u
  (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .ext_reset_req   (ext_reset_req),
    .write_busy      (write_busy),
    .write_done_flag (write_done_flag)
  );

  // Free-running core clock
  always #2 pclk = ~pclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize;
    // Notes left unmatched mean a read never completed
    if (exp_q.size() != 0)
      n_mismatch++;
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  // One transfer; leaves psel high so a following call runs back-to-back
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h000000, d}, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(a, 1'b0, 32'h00000000, {25'h0000000, e});
  endtask

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Key pair, then the control write that should launch the cycle
  task automatic start_w(input logic [7:0] v);
    wr(`EAC_OFS_UNLOCK, 8'h55);
    wr(`EAC_OFS_UNLOCK, 8'hAA);
    wr(`EAC_OFS_CTRL, v);
  endtask

  // Sampled 1 ns past each edge so the edge's own updates have landed
  task automatic busy_len(output int n);
    psel <= 1'b0;
    penable <= 1'b0;
    n = 0;
    #1;
    while (write_busy === 1'b1 && n < 5000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    @(posedge pclk);
  endtask

  // Read results are matched in order against the driver's notes
  always @(posedge pclk)
  begin
    if (presetn && psel && penable && pready && !pwrite)
    begin
      if (exp_q.size() == 0)
        check("unexpected read", 33'h0, 33'h1);
      else
        check($sformatf("register %h", paddr), {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Hang guard, far above the few hundred cycles the tests need
  initial
  begin
    #80000;
    n_mismatch++;
    summarize;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ext_reset_req = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(60736));
    a0 = 8'($urandom);
    d0 = 8'($urandom);
    d2 = d0 ^ 8'h5A;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state, key register, unmapped place
    rd(`EAC_OFS_CTRL, 8'h00);
    rd(`EAC_OFS_UNLOCK, 8'h00);
    rd(`EAC_OFS_ADDR, 8'h00);
    rd(`EAC_OFS_DATA, 8'h00);
    rd(`EAC_OFS_FLAG, 8'h00);
    apb(8'h14, 1'b0, 32'h00000000, {1'b1, 32'h00000000});
    // Normal write, full busy span, then read back
    wr(`EAC_OFS_ADDR, a0);
    wr(`EAC_OFS_DATA, d0);
    wr(`EAC_OFS_CTRL, 8'h04);
    start_w(8'h06);
    busy_len(c);
    check("busy cycles", 33'(c), 33'(WC));
    check("done flag", {32'h0, write_done_flag}, 33'h1);
    rd(`EAC_OFS_CTRL, 8'h04);
    rd(`EAC_OFS_FLAG, 8'h01);
    wr(`EAC_OFS_FLAG, 8'h01);
    rd(`EAC_OFS_FLAG, 8'h00);
    wr(`EAC_OFS_DATA, ~d0);
    wr(`EAC_OFS_CTRL, 8'h05);
    rd(`EAC_OFS_DATA, d0);
    idle;
    rd(`EAC_OFS_CTRL, 8'h04);
    wr(`EAC_OFS_ADDR, ~a0);
    rd(`EAC_OFS_DATA, d0);
    // A stray write in the loop would store d2 at a0 and show below
    wr(`EAC_OFS_ADDR, a0);
    wr(`EAC_OFS_DATA, d2);
    // Broken key sequences, and a start with enable still clear
    seq_a = '{'{`EAC_OFS_UNLOCK, `EAC_OFS_UNLOCK, `EAC_OFS_FLAG},
              '{`EAC_OFS_UNLOCK, `EAC_OFS_ADDR, `EAC_OFS_UNLOCK},
              '{`EAC_OFS_UNLOCK, `EAC_OFS_UNLOCK, `EAC_OFS_UNLOCK},
              '{`EAC_OFS_ADDR, `EAC_OFS_UNLOCK, `EAC_OFS_UNLOCK}};
    seq_d = '{'{8'hAA, 8'h55, 8'h00}, '{8'h55, a0, 8'hAA},
              '{8'h55, 8'h5A, 8'hAA}, '{a0, 8'h55, 8'hAA}};
    for (int k = 0; k < 4; k++)
    begin
      wr(`EAC_OFS_CTRL, (k == 3) ? 8'h00 : 8'h04);
      for (int j = 0; j < 3; j++)
        wr(seq_a[k][j], seq_d[k][j]);
      wr(`EAC_OFS_CTRL, 8'h06);
      rd(`EAC_OFS_CTRL, 8'h04);
    end
    wr(`EAC_OFS_ADDR, a0);
    wr(`EAC_OFS_CTRL, 8'h05);
    rd(`EAC_OFS_DATA, d0);
    // Enable dropped and select poked while the cycle runs
    wr(`EAC_OFS_DATA, d2);
    wr(`EAC_OFS_CTRL, 8'h04);
    start_w(8'h06);
    wr(`EAC_OFS_CTRL, 8'h80);
    rd(`EAC_OFS_CTRL, 8'h02);
    busy_len(c);
    check("busy after disable", 33'(c), 33'(WC - 4));
    check("done after disable", {32'h0, write_done_flag}, 33'h1);
    wr(`EAC_OFS_CTRL, 8'h01);
    rd(`EAC_OFS_DATA, d2);
    wr(`EAC_OFS_FLAG, 8'h01);
    // External reset cuts a write short; the next clean write clears the error
    wr(`EAC_OFS_DATA, d0);
    wr(`EAC_OFS_CTRL, 8'h04);
    start_w(8'h06);
    idle;
    ext_reset_req <= 1'b1;
    repeat (6) @(posedge pclk);
    ext_reset_req <= 1'b0;
    busy_len(c);
    check("busy after abort", 33'(c), 33'h0);
    rd(`EAC_OFS_CTRL, 8'h0C);
    rd(`EAC_OFS_FLAG, 8'h00);
    wr(`EAC_OFS_CTRL, 8'h0D);
    rd(`EAC_OFS_DATA, d2);
    start_w(8'h0E);
    busy_len(c);
    check("busy after error", 33'(c), 33'(WC));
    rd(`EAC_OFS_CTRL, 8'h04);
    wr(`EAC_OFS_CTRL, 8'h00);
    rd(`EAC_OFS_CTRL, 8'h00);
    idle;
    summarize;
  end
endmodule
